// ### verilog/outbound_queue_pointers.sv
`timescale 1ns/1ns
module outbound_queue_pointers
	import outbound_queue_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input  wire logic                                ref_clk,
	input  wire logic                                arst_n,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0]                   s_axi_awaddr,
	input  wire logic                                s_axi_awvalid,
	output logic                                     s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [outbound_queue_pkg::DATA_W-1:0]   s_axi_wdata,
	input  wire logic [outbound_queue_pkg::DATA_W/8-1:0] s_axi_wstrb,
	input  wire logic                                s_axi_wvalid,
	output logic                                     s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                               s_axi_bresp,
	output logic                                     s_axi_bvalid,
	input  wire logic                                s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0]                   s_axi_araddr,
	input  wire logic                                s_axi_arvalid,
	output logic                                     s_axi_arready,
	// AXI4-Lite read data
	output logic [outbound_queue_pkg::DATA_W-1:0]    s_axi_rdata,
	output logic [1:0]                               s_axi_rresp,
	output logic                                     s_axi_rvalid,
	input  wire logic                                s_axi_rready,
	// outbound queue port activity, one-cycle pulses
	input  wire logic                                pciQueueWrite,
	input  wire logic                                pciQueueRead,
	// processor-bus queue base from the bridge configuration
	input  wire logic [outbound_queue_pkg::BASE_W-1:0]   busQueueBase,
	// list state toward the queue port logic
	output logic                                     freeListEmpty,
	output logic                                     postListEmpty,
	output logic [outbound_queue_pkg::OFFSET_W-1:0]  freeHeadOffset,
	output logic [outbound_queue_pkg::OFFSET_W-1:0]  postTailOffset
);

	// limits on the address width, refused at elaboration
	if (ADDR_W < 12) begin : g_addr_narrow
		$error("outbound_queue_pointers: ADDR_W must be at least 12");
	end
	if (ADDR_W > 32) begin : g_addr_wide
		$error("outbound_queue_pointers: ADDR_W must not exceed 32");
	end

	// write channel state
	logic                 awHeld_r;
	logic                 awHeld_nxt;
	logic                 wHeld_r;
	logic                 wHeld_nxt;
	logic [ADDR_W-1:0]    awAddr_r;
	logic [DATA_W-1:0]    wData_r;
	logic [DATA_W/8-1:0]  wStrb_r;
	logic                 bvalid_nxt;
	logic [1:0]           bresp_r;

	// read channel state
	logic                 arready_nxt;
	logic                 rvalid_nxt;

	// pointer bank
	logic [BASE_W-1:0]    baseCopy_r;
	logic [OFFSET_W-1:0]  ptrVal   [NUM_PTRS];
	logic [OFFSET_W-1:0]  ptrLoadV [NUM_PTRS];
	logic [DATA_W-1:0]    ptrImage [NUM_PTRS];
	logic [DATA_W-1:0]    rdPart   [NUM_PTRS];
	logic [NUM_PTRS-1:0]  wrHit;
	logic [NUM_PTRS-1:0]  rdHit;
	logic [NUM_PTRS-1:0]  loadVec;
	logic [NUM_PTRS-1:0]  bumpVec;
	logic                 freeListEmpty_r;
	logic                 postListEmpty_r;

	// handshakes and decode
	wire logic               awTake   = s_axi_awvalid && s_axi_awready;
	wire logic               wTake    = s_axi_wvalid && s_axi_wready;
	wire logic               bDone    = s_axi_bvalid && s_axi_bready;
	wire logic               arTake   = s_axi_arvalid && s_axi_arready;
	wire logic               rDone    = s_axi_rvalid && s_axi_rready;
	wire logic               wrGo     = awHeld_r && wHeld_r && !s_axi_bvalid;
	wire logic [ADDR_W-1:0]  wrWord   = {awAddr_r[ADDR_W-1:2], 2'b00};
	wire logic [ADDR_W-1:0]  rdWord   = {s_axi_araddr[ADDR_W-1:2], 2'b00};
	wire logic               wrTailBp = wrWord == ADDR_W'(OFF_FREE_TAIL_BUMP);
	wire logic               wrHeadBp = wrWord == ADDR_W'(OFF_POST_HEAD_BUMP);
	wire logic               rdBump   = (rdWord == ADDR_W'(OFF_FREE_TAIL_BUMP)) ||
	                                    (rdWord == ADDR_W'(OFF_POST_HEAD_BUMP));
	wire logic               wrMapped = (|wrHit) || wrTailBp || wrHeadBp;
	wire logic               rdMapped = (|rdHit) || rdBump;
	wire logic [DATA_W-1:0]  wrMask   = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}},
	                                     {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
	wire logic               incrOne  = wStrb_r[0] && wData_r[INCREMENT_STROBE_BIT];
	wire logic [DATA_W-1:0]  rdMux    = rdPart[0] | rdPart[1] | rdPart[2] | rdPart[3];

	// increment strobes self-clear: they act in the commit cycle and read back zero
	assign bumpVec[PTR_FREE_TAIL] = wrGo && wrTailBp && incrOne;
	assign bumpVec[PTR_FREE_HEAD] = pciQueueWrite;
	assign bumpVec[PTR_POST_TAIL] = pciQueueRead;
	assign bumpVec[PTR_POST_HEAD] = wrGo && wrHeadBp && incrOne;

	// one slot per pointer: decode, byte-merged load, storage, read image
	for (genvar i = 0; i < NUM_PTRS; i++) begin : g_ptr
		wire logic [DATA_W-1:0] merged = (ptrImage[i] & ~wrMask) | (wData_r & wrMask);

		assign wrHit[i]    = wrWord == ADDR_W'(OFF_PTR[i]);
		assign rdHit[i]    = rdWord == ADDR_W'(OFF_PTR[i]);
		assign loadVec[i]  = wrGo && wrHit[i];
		// base bits of the write are dropped; only the offset field takes data
		assign ptrLoadV[i] = merged[OFFSET_LSB +: OFFSET_W];
		assign ptrImage[i] = {baseCopy_r, ptrVal[i], 2'b00};
		assign rdPart[i]   = rdHit[i] ? ptrImage[i] : DATA_RESET;

		queue_ptr_field #(
			.W         (OFFSET_W),
			.RESET_VAL (PTR_RESET)
		) u_field (
			.ref_clk (ref_clk),
			.arst_n  (arst_n),
			.load    (loadVec[i]),
			.loadVal (ptrLoadV[i]),
			.bump    (bumpVec[i]),
			.value   (ptrVal[i])
		);
	end

	// write address and data are held independently, so either may arrive first
	assign awHeld_nxt  = awTake ? 1'b1 : (bDone ? 1'b0 : awHeld_r);
	assign wHeld_nxt   = wTake ? 1'b1 : (bDone ? 1'b0 : wHeld_r);
	assign bvalid_nxt  = wrGo ? 1'b1 : (bDone ? 1'b0 : s_axi_bvalid);
	assign arready_nxt = arTake ? 1'b0 : (rDone ? 1'b1 : s_axi_arready);
	assign rvalid_nxt  = arTake ? 1'b1 : (rDone ? 1'b0 : s_axi_rvalid);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			awHeld_r      <= 1'b0;
			wHeld_r       <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
		end else begin
			awHeld_r      <= awHeld_nxt;
			wHeld_r       <= wHeld_nxt;
			s_axi_awready <= !awHeld_nxt;
			s_axi_wready  <= !wHeld_nxt;
			s_axi_bvalid  <= bvalid_nxt;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			awAddr_r <= '0;
			wData_r  <= DATA_RESET;
			wStrb_r  <= '0;
			bresp_r  <= RESP_OKAY;
		end else begin
			if (awTake) awAddr_r <= s_axi_awaddr;
			if (wTake) wData_r <= s_axi_wdata;
			if (wTake) wStrb_r <= s_axi_wstrb;
			if (wrGo) bresp_r <= wrMapped ? RESP_OKAY : RESP_DECERR;
		end
	end
	assign s_axi_bresp = bresp_r;

	// one read outstanding; data captured at the address handshake
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= DATA_RESET;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= arready_nxt;
			s_axi_rvalid  <= rvalid_nxt;
			if (arTake) s_axi_rdata <= rdMux;
			if (arTake) s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_DECERR;
		end
	end

	// base copy and list state; the empty flag lags the pointers by one cycle
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			baseCopy_r      <= BASE_RESET;
			freeListEmpty_r <= 1'b1;
			postListEmpty_r <= 1'b1;
		end else begin
			baseCopy_r      <= busQueueBase;
			freeListEmpty_r <= ptrVal[PTR_FREE_TAIL] == ptrVal[PTR_FREE_HEAD];
			postListEmpty_r <= ptrVal[PTR_POST_TAIL] == ptrVal[PTR_POST_HEAD];
		end
	end

	assign freeListEmpty  = freeListEmpty_r;
	assign postListEmpty  = postListEmpty_r;
	assign freeHeadOffset = ptrVal[PTR_FREE_HEAD];
	assign postTailOffset = ptrVal[PTR_POST_TAIL];

	// checks
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	a_tail_bump_adv: assert property (bumpVec[PTR_FREE_TAIL] && !loadVec[PTR_FREE_TAIL] |=>
		ptrVal[PTR_FREE_TAIL] == OFFSET_W'($past(ptrVal[PTR_FREE_TAIL]) + 1'b1))
		else $error("free tail did not advance on bump");

	a_tail_hold_idle: assert property (!wrGo |=> $stable(ptrVal[PTR_FREE_TAIL]))
		else $error("free tail moved without a bus write");

	a_head_pci_adv: assert property (pciQueueWrite && !loadVec[PTR_FREE_HEAD] |=>
		ptrVal[PTR_FREE_HEAD] == OFFSET_W'($past(ptrVal[PTR_FREE_HEAD]) + 1'b1))
		else $error("free head did not advance on queue write");

	a_post_tail_adv: assert property (pciQueueRead && !loadVec[PTR_POST_TAIL] |=>
		ptrVal[PTR_POST_TAIL] == OFFSET_W'($past(ptrVal[PTR_POST_TAIL]) + 1'b1))
		else $error("post tail did not advance on queue read");

	a_head_bump_adv: assert property (wrGo && wrHeadBp && incrOne |=>
		ptrVal[PTR_POST_HEAD] == OFFSET_W'($past(ptrVal[PTR_POST_HEAD]) + 1'b1))
		else $error("post head did not advance on bump");

	a_empty_flag: assert property (##1 freeListEmpty ==
		($past(ptrVal[PTR_FREE_TAIL]) == $past(ptrVal[PTR_FREE_HEAD])))
		else $error("free list empty flag disagrees with pointers");

	a_base_readback: assert property (arTake && (|rdHit) ##1 1'b1 |->
		s_axi_rdata[DATA_W-1:BASE_LSB] == $past(baseCopy_r))
		else $error("read data lacks the base copy");

	a_offset_load: assert property (loadVec[PTR_FREE_HEAD] |=>
		ptrVal[PTR_FREE_HEAD] == $past(ptrLoadV[PTR_FREE_HEAD]))
		else $error("free head did not take the written offset");

	a_head_no_sw: assert property (!pciQueueWrite && !loadVec[PTR_FREE_HEAD] |=>
		$stable(ptrVal[PTR_FREE_HEAD]))
		else $error("free head moved without cause");

	a_low_bits_zero: assert property (s_axi_rvalid |-> s_axi_rdata[1:0] == 2'b00)
		else $error("low read bits not zero");

	a_offset_wrap: assert property (pciQueueRead && !loadVec[PTR_POST_TAIL] &&
		(&ptrVal[PTR_POST_TAIL]) |=> ptrVal[PTR_POST_TAIL] == PTR_RESET)
		else $error("post tail did not wrap to zero");

	a_write_answer: assert property (awHeld_r && wHeld_r && !s_axi_bvalid |=> s_axi_bvalid)
		else $error("write response late");

	a_post_empty_flag: assert property (##1 postListEmpty ==
		($past(ptrVal[PTR_POST_TAIL]) == $past(ptrVal[PTR_POST_HEAD])))
		else $error("post list empty flag disagrees with pointers");

	a_post_head_hold: assert property (!wrGo |=>
		$stable(ptrVal[PTR_POST_HEAD]))
		else $error("post head moved without a bus write");

	a_post_tail_hold: assert property (!pciQueueRead && !loadVec[PTR_POST_TAIL] |=>
		$stable(ptrVal[PTR_POST_TAIL]))
		else $error("post tail moved without cause");

	a_zero_no_bump: assert property (wrGo && wrTailBp && !incrOne |=>
		$stable(ptrVal[PTR_FREE_TAIL]))
		else $error("free tail moved on a write without the strobe");

	a_post_tail_load: assert property (loadVec[PTR_POST_TAIL] |=>
		ptrVal[PTR_POST_TAIL] == $past(ptrLoadV[PTR_POST_TAIL]))
		else $error("post tail did not take the written offset");

	a_bump_reads_zero: assert property (arTake && rdBump |=>
		s_axi_rdata == DATA_RESET && s_axi_rresp == RESP_OKAY)
		else $error("bump register did not read as zero");

	a_unmapped_read: assert property (arTake && !rdMapped |=>
		s_axi_rresp == RESP_DECERR && s_axi_rdata == DATA_RESET)
		else $error("unmapped read not refused");

	a_unmapped_write: assert property (wrGo && !wrMapped |=>
		s_axi_bresp == RESP_DECERR)
		else $error("unmapped write not refused");

	a_read_answer: assert property (arTake |=>
		s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");

	c_tail_bump: cover property (bumpVec[PTR_FREE_TAIL]);
	c_queue_rw: cover property (pciQueueWrite ##[1:8] pciQueueRead);
	c_list_filled: cover property (freeListEmpty ##1 !freeListEmpty);
	c_unmapped_read: cover property (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
	c_head_wrap: cover property (bumpVec[PTR_FREE_HEAD] && (&ptrVal[PTR_FREE_HEAD]));

endmodule : outbound_queue_pointers

// ### verilog/outbound_queue_pkg.sv
package outbound_queue_pkg;

	// geometry of a pointer register image
	localparam int DATA_W     = 32;
	localparam int OFFSET_W   = 18;
	localparam int BASE_W     = 12;
	localparam int NUM_PTRS   = 4;
	localparam int BASE_LSB   = 20;
	localparam int OFFSET_LSB = 2;
	localparam int INCREMENT_STROBE_BIT   = 0;

	// byte addresses of the register bank
	localparam logic [11:0] OFF_FREE_TAIL_PTR  = 12'h528;
	localparam logic [11:0] OFF_FREE_TAIL_BUMP = 12'h52C;
	localparam logic [11:0] OFF_FREE_HEAD_PTR  = 12'h530;
	localparam logic [11:0] OFF_POST_TAIL_PTR  = 12'h534;
	localparam logic [11:0] OFF_POST_HEAD_PTR  = 12'h538;
	localparam logic [11:0] OFF_POST_HEAD_BUMP = 12'h53C;

	// pointer slots, in the order the bank holds them
	localparam int PTR_FREE_TAIL = 0;
	localparam int PTR_FREE_HEAD = 1;
	localparam int PTR_POST_TAIL = 2;
	localparam int PTR_POST_HEAD = 3;
	localparam logic [11:0] OFF_PTR [NUM_PTRS] = '{OFF_FREE_TAIL_PTR, OFF_FREE_HEAD_PTR,
	                                               OFF_POST_TAIL_PTR, OFF_POST_HEAD_PTR};

	// values after primary reset
	localparam logic [17:0] PTR_RESET  = 18'h0_0000;
	localparam logic [11:0] BASE_RESET = 12'h000;
	localparam logic [31:0] DATA_RESET = 32'h0000_0000;

	// AXI4-Lite answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : outbound_queue_pkg

// ### verilog/queue_ptr_field.sv
`timescale 1ns/1ns
module queue_ptr_field #(
	parameter int              W         = 18,
	parameter logic [W-1:0]    RESET_VAL = '0
) (
	// clock and reset
	input  wire logic          ref_clk,
	input  wire logic          arst_n,
	// load from software, advance from the queue port or a bump register write
	input  wire logic          load,
	input  wire logic [W-1:0]  loadVal,
	input  wire logic          bump,
	// current word offset
	output logic      [W-1:0]  value
);

	if (W < 1) begin : g_bad_width
		$error("queue_ptr_field: W must be positive");
	end

	// software load wins over a bump in the same cycle; the load is the newer intent
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			value <= RESET_VAL;
		end else if (load) begin
			value <= loadVal;
		end else if (bump) begin
			// carry out of the top bit is dropped, so the field wraps to zero
			value <= W'(value + 1'b1);
		end
	end

endmodule : queue_ptr_field

// ### verification/queue_port_agent.sv
`timescale 1ns/1ns
module queue_port_agent (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	// command from the bench
	input  wire logic        go,
	input  wire logic        slow,
	input  wire logic [7:0]  wrN,
	input  wire logic [7:0]  rdN,
	input  wire logic [11:0] baseCfg,
	// toward the block; busy goes back to the bench
	output logic             pciQueueWrite,
	output logic             pciQueueRead,
	output logic [11:0]      busQueueBase,
	output logic             busy
);
	logic [7:0] wrLeft_r;
	logic [7:0] rdLeft_r;
	logic       phase_r;
	// slow mode leaves an idle cycle between port accesses
	wire        slot = !go && (!slow || phase_r);
	assign pciQueueWrite = slot && (wrLeft_r != 8'h00);
	assign pciQueueRead  = slot && (rdLeft_r != 8'h00);
	assign busQueueBase  = baseCfg;
	assign busy          = (wrLeft_r != 8'h00) || (rdLeft_r != 8'h00);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wrLeft_r <= 8'h00;
			rdLeft_r <= 8'h00;
			phase_r  <= 1'b0;
		end else if (go) begin
			wrLeft_r <= wrN;
			rdLeft_r <= rdN;
		end else begin
			phase_r <= ~phase_r;
			if (pciQueueWrite) wrLeft_r <= wrLeft_r - 8'h01;
			if (pciQueueRead) rdLeft_r <= rdLeft_r - 8'h01;
		end
	end
endmodule : queue_port_agent

// ### verification/tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin badCount++; \
	$display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb;
	import outbound_queue_pkg::*;
	typedef struct { logic [11:0] a; logic [31:0] d; logic [1:0] br; logic [31:0] rd; logic [1:0] rr; } row_t;
	logic ref_clk = 0, arst_n = 0, go = 0, slow = 0;
	logic [7:0] wrN = 0, rdN = 0;
	logic [11:0] baseCfg = 12'hA5C, s_axi_awaddr = 0, s_axi_araddr = 0, busQueueBase;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 0;
	logic [3:0] strb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
	logic pciQueueWrite, pciQueueRead, freeListEmpty, postListEmpty;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs, bs;
	logic [17:0] freeHeadOffset, postTailOffset;
	int badCount = 0, nChecks = 0;
	row_t rows [6];
	outbound_queue_pointers outbound_queue_pointers_i (.ref_clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .pciQueueWrite, .pciQueueRead, .busQueueBase, .freeListEmpty,
		.postListEmpty, .freeHeadOffset, .postTailOffset);
	queue_port_agent queue_port_agent_i (.ref_clk, .arst_n, .go, .slow, .wrN, .rdN, .baseCfg,
		.pciQueueWrite, .pciQueueRead, .busQueueBase, .busy);
	initial begin
		forever #25 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] img(input logic [11:0] b, input logic [17:0] o);
		return {b, o, 2'b00};
	endfunction : img
	task automatic axiWr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		bit dn;
		dn = 0;
		@(posedge ref_clk);
		s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= strb;
		s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
		while (!dn) begin
			@(posedge ref_clk);
			if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 0;
			if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 0;
			if (s_axi_bvalid) begin r = s_axi_bresp; s_axi_bready <= 0; dn = 1; end
		end
	endtask : axiWr
	task automatic axiRd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		bit dn;
		dn = 0;
		@(posedge ref_clk);
		s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
		while (!dn) begin
			@(posedge ref_clk);
			if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 0;
			if (s_axi_rvalid) begin d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0; dn = 1; end
		end
	endtask : axiRd
	// two extra edges let the registered empty flags catch up
	task automatic runPort(input logic [7:0] w, input logic [7:0] r, input logic s);
		@(posedge ref_clk);
		wrN <= w; rdN <= r; slow <= s; go <= 1;
		@(posedge ref_clk);
		go <= 0;
		@(posedge ref_clk);
		for (int t = 0; t < 600 && busy; t++) @(posedge ref_clk);
		repeat (2) @(posedge ref_clk);
	endtask : runPort
	task automatic tallyAndFinish;
		$display("checks %0d mismatches %0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : tallyAndFinish
	initial begin
		#2000000;
		badCount++;
		tallyAndFinish();
	end
	initial begin
		rows = '{'{12'h528, 32'hFFF0_0104, RESP_OKAY, 32'hA5C0_0104, RESP_OKAY},
			'{12'h530, 32'h0000_0104, RESP_OKAY, 32'hA5C0_0104, RESP_OKAY},
			'{12'h534, 32'h0000_0203, RESP_OKAY, 32'hA5C0_0200, RESP_OKAY},
			'{12'h538, 32'h0000_0200, RESP_OKAY, 32'hA5C0_0200, RESP_OKAY},
			'{12'h52C, 32'h0000_0000, RESP_OKAY, 32'h0000_0000, RESP_OKAY},
			'{12'h540, 32'h1234_5678, RESP_DECERR, 32'h0000_0000, RESP_DECERR}};
		repeat (8) @(posedge ref_clk);
		arst_n <= 1;
		// equal tail and head loads keep both lists empty
		foreach (rows[i]) begin
			axiWr(rows[i].a, rows[i].d, bs);
			`CHK("bresp", rows[i].br, bs)
			axiRd(rows[i].a, rd, rs);
			`CHK("rdata", rows[i].rd, rd)
			`CHK("rresp", rows[i].rr, rs)
		end
		axiRd(12'h528, rd, rs);
		`CHK("free tail zero write", img(12'hA5C, 18'h00041), rd)
		`CHK("free empty", 1'b1, freeListEmpty)
		`CHK("post empty", 1'b1, postListEmpty)
		runPort(8'd3, 8'd0, 1'b0);
		`CHK("free head", 18'h00044, freeHeadOffset)
		`CHK("free not empty", 1'b0, freeListEmpty)
		axiRd(12'h530, rd, rs);
		`CHK("free head reg", img(12'hA5C, 18'h00044), rd)
		repeat (3) axiWr(12'h52C, 32'h0000_0001, bs);
		axiRd(12'h528, rd, rs);
		`CHK("free tail bumped", img(12'hA5C, 18'h00044), rd)
		`CHK("free empty again", 1'b1, freeListEmpty)
		runPort(8'd0, 8'd2, 1'b1);
		`CHK("post tail", 18'h00082, postTailOffset)
		`CHK("post not empty", 1'b0, postListEmpty)
		repeat (2) axiWr(12'h53C, 32'h0000_0003, bs);
		axiRd(12'h538, rd, rs);
		`CHK("post head bumped", img(12'hA5C, 18'h00082), rd)
		`CHK("post empty again", 1'b1, postListEmpty)
		axiWr(12'h530, 32'h000F_FFFC, bs);
		runPort(8'd1, 8'd0, 1'b0);
		`CHK("free head wrap", 18'h00000, freeHeadOffset)
		axiRd(12'h530, rd, rs);
		`CHK("wrap keeps base", img(12'hA5C, 18'h00000), rd)
		baseCfg <= 12'h3C1;
		axiRd(12'h534, rd, rs);
		`CHK("base follows", img(12'h3C1, 18'h00082), rd)
		// strobe byte disabled: the bump must not act
		strb <= 4'hE;
		axiWr(12'h52C, 32'h0000_0001, bs);
		axiRd(12'h528, rd, rs);
		`CHK("masked bump", img(12'h3C1, 18'h00044), rd)
		// one byte enabled: only the low byte merges into the offset
		strb <= 4'h1;
		axiWr(12'h530, 32'hFFFF_FF10, bs);
		axiRd(12'h530, rd, rs);
		`CHK("byte merge", img(12'h3C1, 18'h00004), rd)
		strb <= 4'hF;
		@(posedge ref_clk);
		arst_n <= 0;
		repeat (2) @(posedge ref_clk);
		`CHK("reset head", 18'h00000, freeHeadOffset)
		`CHK("reset empty", 1'b1, freeListEmpty)
		arst_n <= 1;
		axiRd(12'h534, rd, rs);
		`CHK("reset tail reg", img(12'h3C1, 18'h00000), rd)
		tallyAndFinish();
	end
endmodule : tb
